// file: command_host_fifo_config.sv
// module: command, host access and buffer setup register bank
`default_nettype none
module command_host_fifo_config
  import cmd_fifo_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register access from host port logic
  input wire logic addr_load,
  input wire logic [7:0] addr_in,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] addr_ptr,
  // buffer data path
  output logic buf_push,
  output logic buf_pop,
  output logic buf_clear,
  // command and power control
  output logic [4:0] command,
  output logic command_start,
  output logic standby,
  output logic radio_power_down,
  // bus ownership and secure module port
  output logic host_owns_bus,
  output logic secure_module_owns_bus,
  output logic [1:0] secure_module_port_sel,
  output logic spi_port_en,
  output logic slow_two_wire_en,
  output logic two_wire_en,
  // buffer state
  output logic near_full_flag,
  output logic near_empty_flag,
  output logic [9:0] fill_count
);
  import cmd_fifo_cfg_pkg::*;

  // ****************************************
  // register layout
  // ****************************************
  // 00h command_control
  //   [7] standby, power-down request
  //   [6] radio_power_down, receiver and transmitter off
  //   [5] reserved, reads 0
  //   [4:0] command code, any write restarts it
  // 01h host_access_control
  //   [7] host_reg_unlock, cleared by the next write unless it sets the bit
  //   [6] host_owns_bus, set only while unlocked
  //   [5] secure_module_owns_bus, set only while unlocked
  //   [4] reserved, reads 0
  //   [3:2] secure_module_port_sel
  //   [1:0] reserved, read 0
  // 02h buffer_setup
  //   [7] buffer_size_sel, 1 small, 0 large
  //   [6] near_full_flag, read only
  //   [5] near_empty_flag, read only
  //   [4] buffer_clear, write only, reads 0
  //   [3] reserved, reads 0
  //   [2] threshold_msb, used in large mode only
  //   [1:0] fill_count_msbs, read only
  // 03h fill_threshold, threshold_low_bits
  // 04h fill count low byte, read only
  // 05h buffer_port, pointer does not advance

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] cmd_reg;
    logic [7:0] host_reg;
    logic size_sel;
    logic thr_msb;
    logic [7:0] thr_low;
    logic [7:0] ptr;
    logic [7:0] rdat;
    logic rvld;
    logic push;
    logic pop;
    logic clr;
    logic start;
    logic nf;
    logic ne;
    logic [9:0] cnt;
    logic spi_en;
    logic slow_en;
    logic tw_en;
  } st_t;
  st_t q, d;

  logic [7:0] acc_addr;
  logic [9:0] cnt_now;
  logic nf_now;
  logic ne_now;
  logic both_own;
  logic unlocked;

  // ****************************************
  // fill counter and alerts
  // ****************************************
  fill_level_alert #(
    .CNT_W(10)
  ) u_level (
    .clk(clk),
    .sys_rst(sys_rst),
    .push(q.push),
    .pop(q.pop),
    .clear(q.clr),
    .size_small(q.size_sel),
    .threshold({q.thr_msb, q.thr_low}),
    .count(cnt_now),
    .near_full(nf_now),
    .near_empty(ne_now)
  );

  // access address: a fresh address or the running pointer
  assign acc_addr = addr_load ? addr_in : q.ptr;
  assign unlocked = q.host_reg[POS_HOST_REG_UNLOCK];
  assign both_own = wr_data[POS_HOST_OWNS_BUS] && wr_data[POS_SECURE_MODULE_OWNS_BUS];

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    d = q;
    d.rvld = 1'b0;
    d.push = 1'b0;
    d.pop = 1'b0;
    d.clr = 1'b0;
    d.start = 1'b0;
    d.nf = nf_now;
    d.ne = ne_now;
    d.cnt = cnt_now;
    if (addr_load)
    begin
      d.ptr = addr_in;
    end
    if (wr_en)
    begin
      unique case (acc_addr)
        OFS_COMMAND_CONTROL:
        begin
          d.cmd_reg = {wr_data[7:6], 1'b0, wr_data[4:0]};
          d.start = 1'b1;
          d.host_reg[POS_HOST_REG_UNLOCK] = 1'b0;
        end
        OFS_HOST_ACCESS_CONTROL:
        begin
          // unlock bit only survives a write that sets it
          d.host_reg[POS_HOST_REG_UNLOCK] = wr_data[POS_HOST_REG_UNLOCK];
          d.host_reg[POS_PORT_SEL_HI:POS_PORT_SEL_LO] = wr_data[POS_PORT_SEL_HI:POS_PORT_SEL_LO];
          if (!both_own)
          begin
            // setting needs unlock, clearing is always allowed
            d.host_reg[POS_HOST_OWNS_BUS] = wr_data[POS_HOST_OWNS_BUS]
              && (unlocked || q.host_reg[POS_HOST_OWNS_BUS]);
            d.host_reg[POS_SECURE_MODULE_OWNS_BUS] = wr_data[POS_SECURE_MODULE_OWNS_BUS]
              && (unlocked || q.host_reg[POS_SECURE_MODULE_OWNS_BUS]);
          end
        end
        OFS_BUFFER_SETUP:
        begin
          d.size_sel = wr_data[POS_BUFFER_SIZE_SEL];
          d.thr_msb = wr_data[POS_THRESHOLD_MSB];
          d.clr = wr_data[POS_BUFFER_CLEAR];
          d.host_reg[POS_HOST_REG_UNLOCK] = 1'b0;
        end
        OFS_FILL_THRESHOLD:
        begin
          d.thr_low = wr_data;
          d.host_reg[POS_HOST_REG_UNLOCK] = 1'b0;
        end
        OFS_BUFFER_PORT:
        begin
          d.push = 1'b1;
          d.host_reg[POS_HOST_REG_UNLOCK] = 1'b0;
        end
        default:
        begin
          d.host_reg[POS_HOST_REG_UNLOCK] = 1'b0;
        end
      endcase
    end
    else if (rd_en)
    begin
      d.rvld = 1'b1;
      unique case (acc_addr)
        OFS_COMMAND_CONTROL:
        begin
          // reserved bit is held at 0
          d.rdat = q.cmd_reg;
        end
        OFS_HOST_ACCESS_CONTROL:
        begin
          // unlock, ownership and port select
          d.rdat = q.host_reg;
        end
        OFS_BUFFER_SETUP:
        begin
          // live alerts and count msbs, clear bit reads 0
          d.rdat = {q.size_sel, nf_now, ne_now, 1'b0, 1'b0, q.thr_msb,
            cnt_now[9:8]};
        end
        OFS_FILL_THRESHOLD:
        begin
          // low threshold byte
          d.rdat = q.thr_low;
        end
        OFS_FILL_COUNT:
        begin
          // low count byte pairs with setup bits 1:0
          d.rdat = cnt_now[7:0];
        end
        OFS_BUFFER_PORT:
        begin
          d.rdat = 8'h00; // data bytes come from the buffer itself
          d.pop = 1'b1;
        end
        default:
        begin
          // unmapped addresses read 0
          d.rdat = 8'h00;
        end
      endcase
    end
    // pointer advances except on the buffer port
    if ((wr_en || rd_en) && acc_addr != OFS_BUFFER_PORT)
    begin
      d.ptr = acc_addr + 8'h01;
    end
    // decoded secure module port enables
    d.spi_en = port_sel_t'(d.host_reg[POS_PORT_SEL_HI:POS_PORT_SEL_LO]) == PORT_SPI;
    d.slow_en = port_sel_t'(d.host_reg[POS_PORT_SEL_HI:POS_PORT_SEL_LO])
      == PORT_SLOW_TWO_WIRE;
    d.tw_en = port_sel_t'(d.host_reg[POS_PORT_SEL_HI:POS_PORT_SEL_LO]) == PORT_TWO_WIRE;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.cmd_reg <= RST_COMMAND_CONTROL;
      q.host_reg <= RST_HOST_ACCESS_CONTROL;
      q.thr_low <= RST_FILL_THRESHOLD;
      q.size_sel <= RST_BUFFER_SETUP[POS_BUFFER_SIZE_SEL];
      q.ne <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign rd_data = q.rdat;
  assign rd_valid = q.rvld;
  assign addr_ptr = q.ptr;
  assign buf_push = q.push;
  assign buf_pop = q.pop;
  assign buf_clear = q.clr;
  assign command = q.cmd_reg[POS_CMD_HI:0];
  assign command_start = q.start;
  assign standby = q.cmd_reg[POS_STANDBY];
  assign radio_power_down = q.cmd_reg[POS_RADIO_POWER_DOWN];
  assign host_owns_bus = q.host_reg[POS_HOST_OWNS_BUS];
  assign secure_module_owns_bus = q.host_reg[POS_SECURE_MODULE_OWNS_BUS];
  assign secure_module_port_sel = q.host_reg[POS_PORT_SEL_HI:POS_PORT_SEL_LO];
  assign spi_port_en = q.spi_en;
  assign slow_two_wire_en = q.slow_en;
  assign two_wire_en = q.tw_en;
  assign near_full_flag = q.nf;
  assign near_empty_flag = q.ne;
  assign fill_count = q.cnt;
endmodule
`default_nettype wire

// file: cmd_fifo_cfg_pkg.sv
// package: offsets, field positions, reset values, sizes and port encodings of the config bank
`default_nettype none
package cmd_fifo_cfg_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_COMMAND_CONTROL = 8'h00;
  localparam logic [7:0] OFS_HOST_ACCESS_CONTROL = 8'h01;
  localparam logic [7:0] OFS_BUFFER_SETUP = 8'h02;
  localparam logic [7:0] OFS_FILL_THRESHOLD = 8'h03;
  localparam logic [7:0] OFS_FILL_COUNT = 8'h04;
  localparam logic [7:0] OFS_BUFFER_PORT = 8'h05;

  // ****************************************
  // field positions
  // ****************************************
  localparam int POS_STANDBY = 7;
  localparam int POS_RADIO_POWER_DOWN = 6;
  localparam int POS_CMD_HI = 4;
  localparam int POS_HOST_REG_UNLOCK = 7;
  localparam int POS_HOST_OWNS_BUS = 6;
  localparam int POS_SECURE_MODULE_OWNS_BUS = 5;
  localparam int POS_PORT_SEL_HI = 3;
  localparam int POS_PORT_SEL_LO = 2;
  localparam int POS_BUFFER_SIZE_SEL = 7;
  localparam int POS_NEAR_FULL = 6;
  localparam int POS_NEAR_EMPTY = 5;
  localparam int POS_BUFFER_CLEAR = 4;
  localparam int POS_THRESHOLD_MSB = 2;

  // ****************************************
  // reset values and sizes
  // ****************************************
  localparam logic [7:0] RST_COMMAND_CONTROL = 8'h00;
  localparam logic [7:0] RST_HOST_ACCESS_CONTROL = 8'h00;
  localparam logic [7:0] RST_BUFFER_SETUP = 8'h00;
  localparam logic [7:0] RST_FILL_THRESHOLD = 8'h00;
  localparam logic [9:0] SIZE_SMALL = 10'h0ff;
  localparam logic [9:0] SIZE_LARGE = 10'h200;

  // ****************************************
  // secure module port encodings
  // ****************************************
  typedef enum logic [1:0] {
    PORT_OFF = 2'b00,
    PORT_SPI = 2'b01,
    PORT_SLOW_TWO_WIRE = 2'b10,
    PORT_TWO_WIRE = 2'b11
  } port_sel_t;

endpackage
`default_nettype wire

// file: fill_level_alert.sv
// module: buffer fill counter with near-full and near-empty comparison
`default_nettype none
module fill_level_alert
  import cmd_fifo_cfg_pkg::*;
#(
  parameter int CNT_W = 10
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // buffer port strobes and setup
  input wire logic push,
  input wire logic pop,
  input wire logic clear,
  input wire logic size_small,
  input wire logic [8:0] threshold,
  // state
  output logic [CNT_W-1:0] count,
  output logic near_full,
  output logic near_empty
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } st_t;
  st_t q, d;
  logic [CNT_W-1:0] cap;
  logic [CNT_W-1:0] thr;

  // count update, clear wins over strobes
  always_comb
  begin
    d = q;
    if (clear)
    begin
      d.cnt = '0;
    end
    else if (push && !pop && q.cnt < cap)
    begin
      d.cnt = q.cnt + 1'b1;
    end
    else if (pop && !push && q.cnt != '0)
    begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // capacity and threshold, msb only in large mode
  assign cap = size_small ? SIZE_SMALL : SIZE_LARGE;
  assign thr = size_small ? {2'b00, threshold[7:0]} : {1'b0, threshold};
  assign count = q.cnt;
  assign near_full = (cap - q.cnt) <= thr;
  assign near_empty = q.cnt <= thr;
endmodule
`default_nettype wire

// file: host_port_model.sv
// host model issuing register accesses to the config bank
`default_nettype none
module host_port_model (
  // clock and answer
  input wire logic clk,
  input wire logic [7:0] rd_data,
  // access request
  output logic addr_load,
  output logic [7:0] addr_in,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr_load, addr_in, wr_en, rd_en, wr_data} = 19'h0_0000;
  // one access per call, released address and data inverted, load and strobes low
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk);
    {addr_load, addr_in, wr_en, rd_en, wr_data} = {1'b1, a, w, !w, d};
    @(negedge clk);
    {addr_load, addr_in, wr_en, rd_en, wr_data} = {1'b0, ~a, 2'b00, ~d};
    q = rd_data;
  endtask
endmodule
`default_nettype wire

// file: command_host_fifo_config_assertions.sv
// checker for the config bank ports
`default_nettype none
module command_host_fifo_config_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // access request
  input wire logic addr_load,
  input wire logic [7:0] addr_in,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wr_data,
  // observed outputs
  input wire logic [7:0] addr_ptr,
  input wire logic buf_push,
  input wire logic buf_pop,
  input wire logic buf_clear,
  input wire logic [4:0] command,
  input wire logic command_start,
  input wire logic standby,
  input wire logic radio_power_down,
  input wire logic host_owns_bus,
  input wire logic secure_module_owns_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] adr;
  logic [7:0] cmd;
  logic wr01;
  // effective address, command word, ownership write
  assign adr = addr_load ? addr_in : addr_ptr;
  assign cmd = {standby, radio_power_down, 1'b0, command};
  assign wr01 = wr_en && adr == 8'h01;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  chk_cmd_word: assert property (
    wr_en && adr == 8'h00 |=> cmd == ($past(wr_data) & 8'hdf)) else $error("command word");
  chk_cmd_start: assert property (
    wr_en && adr == 8'h00 |=> command_start) else $error("no command start");
  chk_own_excl: assert property (
    !(host_owns_bus && secure_module_owns_bus)) else $error("two owners");
  chk_own_hold: assert property (
    !wr01 |=> $stable({host_owns_bus, secure_module_owns_bus})) else $error("owner moved");
  chk_both_set: assert property (
    wr01 && wr_data[6] && wr_data[5] |=> $stable({host_owns_bus, secure_module_owns_bus}))
    else $error("double owner taken");
  chk_push_pulse: assert property (
    wr_en && adr == 8'h05 |=> buf_push) else $error("no push");
  chk_pop_pulse: assert property (
    rd_en && !wr_en && adr == 8'h05 |=> buf_pop) else $error("no pop");
  chk_clear_pulse: assert property (
    wr_en && adr == 8'h02 && wr_data[4] |=> buf_clear) else $error("no clear");
  chk_ptr_hold: assert property (
    (wr_en || rd_en) && adr == 8'h05 |=> addr_ptr == 8'h05) else $error("pointer moved");
  chk_ptr_step: assert property (
    (wr_en || rd_en) && adr != 8'h05 |=> addr_ptr == $past(adr) + 8'h01)
    else $error("pointer not stepped");
  // main scenarios
  cover property (wr01 && wr_data[7]);
  cover property (buf_push);
  cover property (command_start);
endmodule
bind command_host_fifo_config command_host_fifo_config_assertions u_chk (
  .clk, .sys_rst, .addr_load, .addr_in, .wr_en, .rd_en, .wr_data, .addr_ptr, .buf_push,
  .buf_pop, .buf_clear,
  .command, .command_start, .standby, .radio_power_down, .host_owns_bus,
  .secure_module_owns_bus
);
`default_nettype wire

// file: command_host_fifo_config_test.sv
// self-checking bench for the config register bank
`default_nettype none
module command_host_fifo_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic addr_load, wr_en, rd_en, rd_valid, buf_push, buf_pop, buf_clear, command_start;
  logic standby, radio_power_down, host_owns_bus, secure_module_owns_bus;
  logic spi_port_en, slow_two_wire_en, two_wire_en, near_full_flag, near_empty_flag;
  logic [7:0] addr_in, wr_data, rd_data, addr_ptr, q;
  logic [4:0] command;
  logic [1:0] secure_module_port_sel;
  logic [9:0] fill_count, cmdw, own, sel, alerts;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  // observed groups
  assign cmdw = {3'b000, standby, radio_power_down, command};
  assign own = {8'h00, host_owns_bus, secure_module_owns_bus};
  assign sel = {5'h00, secure_module_port_sel, spi_port_en, slow_two_wire_en, two_wire_en};
  assign alerts = {8'h00, near_full_flag, near_empty_flag};
  command_host_fifo_config uut (
    .clk, .sys_rst, .addr_load, .addr_in, .wr_en, .rd_en, .wr_data, .rd_data, .rd_valid,
    .addr_ptr, .buf_push, .buf_pop, .buf_clear, .command, .command_start, .standby,
    .radio_power_down, .host_owns_bus, .secure_module_owns_bus, .secure_module_port_sel,
    .spi_port_en, .slow_two_wire_en, .two_wire_en, .near_full_flag, .near_empty_flag,
    .fill_count
  );
  host_port_model host (.clk, .rd_data, .addr_load, .addr_in, .wr_en, .rd_en, .wr_data);
  // clock
  initial forever #12.5 clk = ~clk;
  // compare and count
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // register access helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00, q);
    chk({1'b0, rd_valid, q}, {2'b01, e});
  endtask
  // let count and alerts land
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_reset;
    chk(alerts, 10'h001);
    chk(fill_count, 10'h000);
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h20);
    rd(8'h40, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_cmd;
    wr(8'h00, 8'hc5);
    chk(cmdw, 10'h065);
    wr(8'h00, 8'h5f);
    chk(cmdw, 10'h03f);
    wr(8'h00, 8'h00);
    chk(cmdw, 10'h000);
    $display("command test done");
  endtask
  task automatic t_own;
    wr(8'h01, 8'h40);
    chk(own, 10'h000);
    wr(8'h01, 8'h80);
    wr(8'h01, 8'h60);
    chk(own, 10'h000);
    wr(8'h01, 8'h80);
    wr(8'h01, 8'h40);
    chk(own, 10'h002);
    wr(8'h01, 8'h80);
    wr(8'h01, 8'h20);
    chk(own, 10'h001);
    wr(8'h01, 8'h80);
    wr(8'h03, 8'h00);
    wr(8'h01, 8'h40);
    chk(own, 10'h000);
    wr(8'h01, 8'h80);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h20);
    chk(own, 10'h000);
    $display("ownership test done");
  endtask
  task automatic t_port;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h01, 8'(i << 2));
      chk(sel, {5'h00, 2'(i), i == 1, i == 2, i == 3});
      rd(8'h01, 8'(i << 2));
    end
    $display("port test done");
  endtask
  task automatic t_fill;
    wr(8'h03, 8'h02);
    wr(8'h02, 8'h00);
    repeat (3) wr(8'h05, 8'ha5);
    host.acc(1'b0, 8'h05, 8'h00, q);
    settle;
    chk(fill_count, 10'h002);
    chk(alerts, 10'h001);
    chk({2'b00, addr_ptr}, 10'h005);
    rd(8'h04, 8'h02);
    wr(8'h02, 8'h10);
    settle;
    chk(fill_count, 10'h000);
    wr(8'h02, 8'h80);
    wr(8'h03, 8'hfd);
    rd(8'h03, 8'hfd);
    repeat (2) wr(8'h05, 8'h5a);
    settle;
    rd(8'h02, 8'he0);
    wr(8'h03, 8'h00);
    wr(8'h02, 8'h84);
    settle;
    chk(alerts, 10'h000);
    wr(8'h02, 8'h04);
    settle;
    rd(8'h02, 8'h24);
    repeat (256) wr(8'h05, 8'h3c);
    settle;
    rd(8'h02, 8'h45);
    rd(8'h04, 8'h02);
    $display("buffer test done");
  endtask
  // counts and verdict
  task automatic test_done;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // reset then scenarios
  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_cmd();
    t_own();
    t_port();
    t_fill();
    test_done();
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      test_done();
    end
  end
endmodule
`default_nettype wire
